// ---- shared/scps_map.svh ----
`ifndef SCPS_MAP_SVH
`define SCPS_MAP_SVH

// Register map size and the commit register.
`define SCPS_REG_COUNT 32'h0000_0235
`define SCPS_COMMIT_ADDR 16'h0234
`define SCPS_COMMIT_BIT 0
`define SCPS_REG_RESET 8'h00

// SPI framing.
`define SCPS_INSTR_LAST 4'hF
`define SCPS_BYTE_LAST 4'h7
`define SCPS_LEN_STREAM 2'h3

// I2C framing: upper five bits of the slave address and the acknowledge slot.
`define SCPS_I2C_ADDR_HI 5'h18
`define SCPS_I2C_ACK_SLOT 4'h8

// Strap settle time in system clocks after reset release.
`define SCPS_STRAP_WAIT 2'h3

`endif

// ---- shared/scps_pkg.sv ----
`default_nettype none

package scps_pkg;

  typedef enum logic [1:0] {
    SCPS_PH_INSTR = 2'b00,
    SCPS_PH_DATA = 2'b01,
    SCPS_PH_DONE = 2'b10
  } scps_phase_t;

  typedef enum logic [2:0] {
    SCPS_I2C_IDLE = 3'b000,
    SCPS_I2C_DEV = 3'b001,
    SCPS_I2C_PHI = 3'b010,
    SCPS_I2C_PLO = 3'b011,
    SCPS_I2C_WR = 3'b100,
    SCPS_I2C_RD = 3'b101
  } scps_i2c_state_t;

  typedef struct packed {
    logic rd;
    logic [1:0] len;
    logic addr_top;
    logic [11:0] addr;
  } scps_instr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } scps_wr_t;

endpackage

`default_nettype wire

// ---- rtl/scps_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; only the second stage is visible outside.
module scps_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // scps_sync

`default_nettype wire

// ---- rtl/scps_i2c.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scps_map.svh"

// I2C slave with 16-bit register pointer, oversampled on the system clock.
module scps_i2c (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [1:0] addr_low,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] rd_data,
  output logic sda_oe,
  output logic wr_valid,
  output scps_pkg::scps_wr_t wr,
  output logic [15:0] ptr
);

  scps_pkg::scps_i2c_state_t st_q;
  logic scl_q, sda_q;
  logic [3:0] bitc_q;
  logic [7:0] sh_q;

  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_seen = scl & scl_q & sda_q & ~sda;
  wire stop_seen = scl & scl_q & ~sda_q & sda;
  wire dev_match = sh_q[7:1] == {`SCPS_I2C_ADDR_HI, addr_low};
  wire ack_slot = bitc_q == `SCPS_I2C_ACK_SLOT;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= scps_pkg::SCPS_I2C_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bitc_q <= 4'h0;
      sh_q <= 8'h00;
      ptr <= 16'h0000;
      sda_oe <= 1'b0;
      wr_valid <= 1'b0;
      wr <= '0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      wr_valid <= 1'b0;
      if (!enable || stop_seen) begin
        st_q <= scps_pkg::SCPS_I2C_IDLE;
        sda_oe <= 1'b0;
      end else if (start_seen) begin
        // A repeated start keeps the pointer for the combined read.
        st_q <= scps_pkg::SCPS_I2C_DEV;
        bitc_q <= 4'h0;
        sda_oe <= 1'b0;
      end else if (st_q != scps_pkg::SCPS_I2C_IDLE && scl_rise) begin
        if (ack_slot) begin
          bitc_q <= 4'h0;
          if (st_q == scps_pkg::SCPS_I2C_RD && sda) begin
            st_q <= scps_pkg::SCPS_I2C_IDLE;
          end
        end else begin
          sh_q <= {sh_q[6:0], sda};
          bitc_q <= bitc_q + 4'h1;
          if (st_q == scps_pkg::SCPS_I2C_RD && bitc_q == `SCPS_BYTE_LAST) begin
            ptr <= ptr + 16'h0001;
          end
        end
      end else if (st_q != scps_pkg::SCPS_I2C_IDLE && scl_fall) begin
        if (ack_slot) begin
          unique case (st_q)
            scps_pkg::SCPS_I2C_DEV: begin
              sda_oe <= dev_match;
              if (!dev_match) begin
                st_q <= scps_pkg::SCPS_I2C_IDLE;
              end else if (sh_q[0]) begin
                st_q <= scps_pkg::SCPS_I2C_RD;
              end else begin
                st_q <= scps_pkg::SCPS_I2C_PHI;
              end
            end
            scps_pkg::SCPS_I2C_PHI: begin
              ptr[15:8] <= sh_q;
              sda_oe <= 1'b1;
              st_q <= scps_pkg::SCPS_I2C_PLO;
            end
            scps_pkg::SCPS_I2C_PLO: begin
              ptr[7:0] <= sh_q;
              sda_oe <= 1'b1;
              st_q <= scps_pkg::SCPS_I2C_WR;
            end
            scps_pkg::SCPS_I2C_WR: begin
              wr_valid <= 1'b1;
              wr <= {ptr, sh_q};
              ptr <= ptr + 16'h0001;
              sda_oe <= 1'b1;
            end
            scps_pkg::SCPS_I2C_RD: begin
              sda_oe <= 1'b0;
            end
            default: begin
              st_q <= scps_pkg::SCPS_I2C_IDLE;
              sda_oe <= 1'b0;
            end
          endcase
        end else begin
          sda_oe <= st_q == scps_pkg::SCPS_I2C_RD && !rd_data[3'h7 - bitc_q[2:0]];
        end
      end
    end
  end

  property p_i2c_write_steps;
    @(posedge clock) disable iff (!rst_n)
    wr_valid |-> ptr == wr.addr + 16'h0001;
  endproperty
  a_i2c_write_steps: assert property (p_i2c_write_steps)
    else $error("I2C pointer did not step after a data byte.");

endmodule // scps_i2c

`default_nettype wire

// ---- rtl/scps_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scps_map.svh"

module scps_top #(
  parameter int REG_COUNT = `SCPS_REG_COUNT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] mode_strap,
  input wire logic four_wire,
  input wire logic readback_shadow,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic readback_output_pin,
  output logic readback_output_pin_oe,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic [REG_COUNT-1:0][7:0] active_regs_q
);

  localparam int AW = $clog2(REG_COUNT);

  // System clock domain: straps, I2C, shadow and active registers.
  logic [2:0] cfg_c;
  logic [1:0] scl_sda_s;
  logic [1:0] strap_cnt_q;
  logic i2c_en_q;
  logic [1:0] i2c_low_q;
  logic tog_s, tog_d_q;
  logic [REG_COUNT-1:0][7:0] shadow_q;
  logic i2c_wr_valid;
  scps_pkg::scps_wr_t i2c_wr;
  logic [15:0] i2c_ptr;
  logic [7:0] i2c_rd_data;

  // Link domain: SPI engine on the serial clock.
  logic link_rst_n;
  logic [1:0] link_cfg_s;
  logic cs_gap_q;
  scps_pkg::scps_phase_t phase_q;
  scps_pkg::scps_phase_t eff_phase;
  logic [3:0] bit_cnt_q;
  logic [3:0] eff_cnt;
  logic [15:0] shift_q;
  logic rd_q, stream_q, past_end_q;
  logic [1:0] left_q;
  logic [12:0] addr_q;
  scps_pkg::scps_wr_t spi_wr_q;
  logic spi_tog_q;
  logic [7:0] link_rd_byte;

  scps_sync #(.WIDTH(3)) u_cfg_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({readback_shadow, mode_strap}),
    .sync_out(cfg_c)
  );

  scps_sync #(.WIDTH(2), .RESET_VAL(2'b11)) u_i2c_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({scl, sda_i}),
    .sync_out(scl_sda_s)
  );

  scps_sync #(.WIDTH(1)) u_tog_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(spi_tog_q),
    .sync_out(tog_s)
  );

  // The straps are sampled on the first three clocks and then held; the last sample is taken after the synchroniser has settled.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strap_cnt_q <= 2'h0;
      i2c_en_q <= 1'b0;
      i2c_low_q <= 2'h0;
    end else if (strap_cnt_q != `SCPS_STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      i2c_en_q <= cfg_c[1:0] != 2'h0;
      i2c_low_q <= cfg_c[1:0] - 2'h1;
    end
  end

  scps_i2c u_i2c (
    .clock(clock),
    .rst_n(rst_n),
    .enable(i2c_en_q),
    .addr_low(i2c_low_q),
    .scl(scl_sda_s[1]),
    .sda(scl_sda_s[0]),
    .rd_data(i2c_rd_data),
    .sda_oe(sda_oe),
    .wr_valid(i2c_wr_valid),
    .wr(i2c_wr),
    .ptr(i2c_ptr)
  );

  // SPI write events arrive as a toggle; the byte itself is held for eight serial clocks.
  // A toggle left over from before a reset is ignored until the straps have settled.
  wire spi_go = (tog_s ^ tog_d_q) && strap_cnt_q == `SCPS_STRAP_WAIT;
  wire wr_go = i2c_en_q ? i2c_wr_valid : spi_go;
  scps_pkg::scps_wr_t wr_ev;
  assign wr_ev = i2c_en_q ? i2c_wr : spi_wr_q;
  wire wr_in_range = wr_ev.addr < 16'(REG_COUNT);
  wire commit = wr_go && wr_in_range && wr_ev.addr == `SCPS_COMMIT_ADDR
    && wr_ev.data[`SCPS_COMMIT_BIT];
  wire [7:0] wr_byte = commit ? (wr_ev.data & ~(8'h01 << `SCPS_COMMIT_BIT)) : wr_ev.data;
  wire [7:0] shadow0 = shadow_q[0];
  wire [7:0] active0 = active_regs_q[0];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tog_d_q <= 1'b0;
      shadow_q <= {REG_COUNT{`SCPS_REG_RESET}};
      active_regs_q <= {REG_COUNT{`SCPS_REG_RESET}};
    end else begin
      tog_d_q <= tog_s;
      if (wr_go && wr_in_range) begin
        shadow_q[wr_ev.addr[AW-1:0]] <= wr_byte;
      end
      if (commit) begin
        for (int i = 0; i < REG_COUNT; i++) begin
          active_regs_q[i] <= shadow_q[i];
        end
        active_regs_q[wr_ev.addr[AW-1:0]] <= wr_byte;
      end
    end
  end

  wire i2c_rd_ok = i2c_ptr < 16'(REG_COUNT);
  assign i2c_rd_data = !i2c_rd_ok ? 8'h00
    : cfg_c[2] ? shadow_q[i2c_ptr[AW-1:0]] : active_regs_q[i2c_ptr[AW-1:0]];

  always_ff @(posedge clock) begin
    sda_o <= 1'b0;
  end

  // Link domain reset and configuration.
  scps_sync #(.WIDTH(1)) u_link_rst (
    .clock(sclk),
    .rst_n(1'b1),
    .async_in(rst_n),
    .sync_out(link_rst_n)
  );

  scps_sync #(.WIDTH(2)) u_link_cfg (
    .clock(sclk),
    .rst_n(link_rst_n),
    .async_in({four_wire, readback_shadow}),
    .sync_out(link_cfg_s)
  );

  // Marks that select has been high since the last serial clock edge.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cs_gap_q <= 1'b1;
    end else begin
      cs_gap_q <= 1'b0;
    end
  end

  // A gap mid-byte, after the last byte, or in streaming starts a new instruction.
  wire restart = cs_gap_q && (bit_cnt_q[2:0] != 3'h0
    || phase_q == scps_pkg::SCPS_PH_DONE
    || (phase_q == scps_pkg::SCPS_PH_DATA && stream_q));
  assign eff_phase = restart ? scps_pkg::SCPS_PH_INSTR : phase_q;
  assign eff_cnt = restart ? 4'h0 : bit_cnt_q;
  wire [15:0] shift_nx = {shift_q[14:0], sdio_i};
  scps_pkg::scps_instr_t instr;
  assign instr = shift_nx;
  wire instr_done = eff_phase == scps_pkg::SCPS_PH_INSTR && eff_cnt == `SCPS_INSTR_LAST;
  wire byte_done = eff_phase == scps_pkg::SCPS_PH_DATA && eff_cnt == `SCPS_BYTE_LAST;
  wire addr_ok = !past_end_q && 32'(addr_q) < REG_COUNT;

  always_ff @(posedge sclk) begin
    if (!link_rst_n) begin
      phase_q <= scps_pkg::SCPS_PH_INSTR;
      bit_cnt_q <= 4'h0;
      shift_q <= 16'h0000;
      rd_q <= 1'b0;
      stream_q <= 1'b0;
      past_end_q <= 1'b0;
      left_q <= 2'h0;
      addr_q <= 13'h0000;
      spi_wr_q <= '0;
      spi_tog_q <= 1'b0;
    end else if (!cs_n) begin
      shift_q <= shift_nx;
      bit_cnt_q <= (instr_done || byte_done) ? 4'h0 : eff_cnt + 4'h1;
      unique case (eff_phase)
        scps_pkg::SCPS_PH_INSTR: begin
          phase_q <= instr_done ? scps_pkg::SCPS_PH_DATA : scps_pkg::SCPS_PH_INSTR;
          if (instr_done) begin
            rd_q <= instr.rd;
            stream_q <= instr.len == `SCPS_LEN_STREAM;
            left_q <= instr.len;
            addr_q <= {instr.addr_top, instr.addr};
            past_end_q <= 1'b0;
          end
        end
        scps_pkg::SCPS_PH_DATA: begin
          if (byte_done) begin
            if (!rd_q && addr_ok) begin
              spi_wr_q <= {3'h0, addr_q, shift_nx[7:0]};
              spi_tog_q <= ~spi_tog_q;
            end
            addr_q <= addr_q - 13'h0001;
            past_end_q <= past_end_q || addr_q == 13'h0000;
            if (!stream_q) begin
              left_q <= left_q - 2'h1;
              if (left_q == 2'h0) begin
                phase_q <= scps_pkg::SCPS_PH_DONE;
              end
            end
          end
        end
        scps_pkg::SCPS_PH_DONE: begin
          phase_q <= scps_pkg::SCPS_PH_DONE;
        end
        default: begin
          phase_q <= scps_pkg::SCPS_PH_INSTR;
        end
      endcase
    end
  end

  // With I2C off, register contents only change when this port writes or commits, so the
  // readback path sees settled values long before the next falling edge.
  assign link_rd_byte = !addr_ok ? 8'h00
    : link_cfg_s[0] ? shadow_q[addr_q[AW-1:0]] : active_regs_q[addr_q[AW-1:0]];
  wire link_drive = phase_q == scps_pkg::SCPS_PH_DATA && rd_q;
  wire link_bit = link_rd_byte[3'h7 - bit_cnt_q[2:0]];

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdio_oe <= 1'b0;
      readback_output_pin_oe <= 1'b0;
      sdio_o <= 1'b0;
      readback_output_pin <= 1'b0;
    end else if (!link_rst_n) begin
      sdio_oe <= 1'b0;
      readback_output_pin_oe <= 1'b0;
      sdio_o <= 1'b0;
      readback_output_pin <= 1'b0;
    end else begin
      sdio_oe <= link_drive && !link_cfg_s[1];
      readback_output_pin_oe <= link_drive && link_cfg_s[1];
      sdio_o <= link_bit;
      readback_output_pin <= link_bit;
    end
  end

  property p_release_on_cs;
    @(posedge sclk) disable iff (!link_rst_n)
    cs_n |-> !sdio_oe && !readback_output_pin_oe;
  endproperty
  a_release_on_cs: assert property (p_release_on_cs)
    else $error("Data drivers enabled while select is high.");

  property p_one_driver;
    @(negedge sclk) disable iff (!link_rst_n)
    readback_output_pin_oe |-> !sdio_oe && link_cfg_s[1];
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("Wrong readback pin driven.");

  property p_instr_len;
    @(posedge sclk) disable iff (!link_rst_n)
    (!cs_n && !cs_gap_q && phase_q == scps_pkg::SCPS_PH_INSTR && bit_cnt_q < 4'hF)
      |=> phase_q == scps_pkg::SCPS_PH_INSTR;
  endproperty
  a_instr_len: assert property (p_instr_len)
    else $error("Data phase began before sixteen instruction bits.");

  property p_instr_end;
    @(posedge sclk) disable iff (!link_rst_n)
    (!cs_n && !cs_gap_q && phase_q == scps_pkg::SCPS_PH_INSTR && bit_cnt_q == 4'hF)
      |=> phase_q == scps_pkg::SCPS_PH_DATA && stream_q == ($past(instr.len) == 2'h3)
        && bit_cnt_q == 4'h0;
  endproperty
  a_instr_end: assert property (p_instr_end)
    else $error("Instruction not decoded on the sixteenth edge.");

  property p_addr_down;
    @(posedge sclk) disable iff (!link_rst_n)
    (!cs_n && !cs_gap_q && phase_q == scps_pkg::SCPS_PH_DATA && bit_cnt_q == 4'h7)
      |=> addr_q == $past(addr_q) - 13'h0001;
  endproperty
  a_addr_down: assert property (p_addr_down)
    else $error("Address did not decrement after a data byte.");

  property p_mid_byte_restart;
    @(posedge sclk) disable iff (!link_rst_n)
    (!cs_n && cs_gap_q && bit_cnt_q[2:0] != 3'h0)
      |=> phase_q == scps_pkg::SCPS_PH_INSTR && bit_cnt_q == 4'h1;
  endproperty
  a_mid_byte_restart: assert property (p_mid_byte_restart)
    else $error("Select rise inside a byte did not restart the port.");

  property p_last_byte_done;
    @(posedge sclk) disable iff (!link_rst_n)
    (!cs_n && !cs_gap_q && phase_q == scps_pkg::SCPS_PH_DATA && !stream_q
      && left_q == 2'h0 && bit_cnt_q == 4'h7) |=> phase_q == scps_pkg::SCPS_PH_DONE;
  endproperty
  a_last_byte_done: assert property (p_last_byte_done)
    else $error("Counted transfer did not end after its last byte.");

  property p_stream_holds;
    @(posedge sclk) disable iff (!link_rst_n)
    (!cs_n && !cs_gap_q && phase_q == scps_pkg::SCPS_PH_DATA && stream_q)
      |=> phase_q == scps_pkg::SCPS_PH_DATA;
  endproperty
  a_stream_holds: assert property (p_stream_holds)
    else $error("Streaming left the data phase without a select rise.");

  property p_commit_copies;
    @(posedge clock) disable iff (!rst_n)
    (commit && wr_ev.addr != 16'h0000) |=> active0 == $past(shadow0);
  endproperty
  a_commit_copies: assert property (p_commit_copies)
    else $error("Commit did not copy the shadow buffer.");

endmodule // scps_top

`default_nettype wire

// ---- tb/scps_host.sv ----
`timescale 1ns/1ps
`default_nettype none

// Serial host that drives the control port with an 80 ns serial clock.
module scps_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    scl = 1'b1;
    sda_drv = 1'b1;
    // Select rises just after time zero so the select-driven clears see a real edge.
    #1 cs_n = 1'b1;
  end

  // Free clocks with select high, used only while the link side leaves reset.
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
  endtask

  task automatic select();
    cs_n = 1'b0;
    #40;
  endtask

  // Outside idle_clocks, the serial clock rests low while select is high.
  task automatic release_cs();
    #40 cs_n = 1'b1;
    #80;
  endtask

  // Open-drain master: a one releases the data line, which is sampled mid-high.
  task automatic i2c_bit(input logic tx, output logic rx);
    #40 sda_drv = tx;
    #40 scl = 1'b1;
    #40 rx = sda;
    #40 scl = 1'b0;
  endtask

  // Serves as start from idle and as repeated start with the clock low.
  task automatic i2c_start();
    #40 sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
  endtask

  task automatic i2c_stop();
    #40 sda_drv = 1'b0;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
  endtask

  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
      output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(tx[i], rx[i]);
    end
    i2c_bit(ack_in, ack_out);
  endtask

  // Data changes while the clock is low; read data is taken at the rising edge.
  task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = tx[i];
      #40 sclk = 1'b1;
      rx[i] = miso;
      #40 sclk = 1'b0;
    end
  endtask

  // In a read the host's own drive changes every byte, so a silent device is seen.
  task automatic frame(input logic rd, input logic [1:0] len, input logic [11:0] addr,
      input int nbytes, input logic [31:0] wdata, input bit stall,
      output logic [31:0] rdata);
    logic [31:0] junk;
    rdata = '0;
    select();
    shift(16, {16'h0000, rd, len, 1'b0, addr}, junk);
    for (int k = 0; k < nbytes; k++) begin
      if (stall) begin
        release_cs();
        select();
      end
      shift(8, rd ? (32'hA5 ^ k) : (wdata >> (8 * (nbytes - 1 - k))), junk);
      rdata = {rdata[23:0], junk[7:0]};
    end
    release_cs();
  endtask
endmodule // scps_host

`default_nettype wire

// ---- tb/scps_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scps_map.svh"

`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("FAIL %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module scps_top_tb;
  logic clock;
  logic rst_n;
  logic [1:0] mode_strap;
  logic four_wire;
  logic readback_shadow;
  logic wrong_pin;
  logic seen_pin;
  int failures;
  int compares;
  wire logic sclk;
  wire logic cs_n;
  wire logic mosi;
  wire logic sdio_o;
  wire logic sdio_oe;
  wire logic rb_pin;
  wire logic rb_pin_oe;
  wire logic sda_o;
  wire logic sda_oe;
  wire logic i2c_scl;
  wire logic i2c_sda_drv;
  wire logic [`SCPS_REG_COUNT-1:0][7:0] regs;
  wire logic sdio_line = sdio_oe ? sdio_o : mosi;
  wire logic miso = four_wire ? rb_pin : sdio_line;
  wire logic sda_line = i2c_sda_drv & (sda_oe ? sda_o : 1'b1);

  scps_top i_scps_top (
    .clock(clock), .rst_n(rst_n), .mode_strap(mode_strap), .four_wire(four_wire),
    .readback_shadow(readback_shadow), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_line),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .readback_output_pin(rb_pin),
    .readback_output_pin_oe(rb_pin_oe), .scl(i2c_scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .active_regs_q(regs)
  );

  scps_host i_scps_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .scl(i2c_scl),
    .sda_drv(i2c_sda_drv), .sda(sda_line));

  always #4 clock = ~clock;

  always @(posedge sclk) begin
    if (four_wire && sdio_oe) begin
      wrong_pin = 1'b1;
    end
    if (four_wire && rb_pin_oe) begin
      seen_pin = 1'b1;
    end
  end

  task automatic results();
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Configuration inputs are quasi-static, so they only change between frames.
  task automatic cfg(input logic fw, input logic shadow);
    @(negedge clock);
    four_wire = fw;
    readback_shadow = shadow;
    repeat (4) @(negedge clock);
  endtask

  task automatic wr(input logic [1:0] len, input logic [11:0] a, input int n,
      input logic [31:0] d, input bit stall = 1'b0);
    logic [31:0] junk;
    i_scps_host.frame(1'b0, len, a, n, d, stall, junk);
  endtask

  task automatic rd_chk(input string what, input logic [1:0] len, input logic [11:0] a,
      input int n, input logic [31:0] exp);
    logic [31:0] got;
    i_scps_host.frame(1'b1, len, a, n, 32'h0, 1'b0, got);
    `CHK(what, exp, got)
  endtask

  task automatic t_reset();
    `CHK("sdio_oe idle", 1'b0, sdio_oe)
    `CHK("pin_oe idle", 1'b0, rb_pin_oe)
    `CHK("active reset", 8'h00, regs[12'h005])
    rd_chk("reset readback", 2'b00, 12'h005, 1, 32'h0);
  endtask

  task automatic t_commit();
    cfg(1'b0, 1'b0);
    wr(2'b00, 12'h005, 1, 32'h3C);
    rd_chk("active before commit", 2'b00, 12'h005, 1, 32'h00);
    `CHK("flop before commit", 8'h00, regs[12'h005])
    cfg(1'b0, 1'b1);
    rd_chk("shadow readback", 2'b00, 12'h005, 1, 32'h3C);
    wr(2'b00, 12'h234, 1, 32'h01);
    `CHK("active after commit", 8'h3C, regs[12'h005])
    `CHK("commit self clears", 1'b0, regs[`SCPS_COMMIT_ADDR][0])
  endtask

  task automatic t_multi();
    cfg(1'b0, 1'b0);
    wr(2'b10, 12'h012, 3, 32'h112233, 1'b1);
    wr(2'b00, 12'h234, 1, 32'h01);
    `CHK("first byte at start", 8'h11, regs[12'h012])
    `CHK("third byte two below", 8'h33, regs[12'h010])
    for (int k = 0; k < 3; k++) begin
      rd_chk("length code read", 2'(k), 12'h012, k + 1, 32'h112233 >> (8 * (2 - k)));
    end
    // The device must fall silent after one byte, so the host's own drive shows.
    rd_chk("count ends read", 2'b00, 12'h012, 2, 32'h11A4);
    `CHK("sdio released", 1'b0, sdio_oe)
  endtask

  task automatic t_stream();
    wr(2'b11, 12'h203, 4, 32'hDEADBEEF);
    cfg(1'b1, 1'b1);
    wrong_pin = 1'b0;
    seen_pin = 1'b0;
    rd_chk("stream four wire", 2'b11, 12'h203, 4, 32'hDEADBEEF);
    `CHK("sdio quiet in four wire", 1'b0, wrong_pin)
    `CHK("output pin driven", 1'b1, seen_pin)
    `CHK("output pin released", 1'b0, rb_pin_oe)
  endtask

  task automatic t_abort();
    logic [31:0] junk;
    cfg(1'b0, 1'b1);
    wr(2'b00, 12'h030, 1, 32'h77);
    i_scps_host.select();
    i_scps_host.shift(16, 32'h0030, junk);
    i_scps_host.shift(5, 32'h1F, junk);
    i_scps_host.release_cs();
    i_scps_host.select();
    i_scps_host.shift(16, 32'h2031, junk);
    i_scps_host.release_cs();
    i_scps_host.select();
    i_scps_host.shift(3, 32'h7, junk);
    i_scps_host.release_cs();
    rd_chk("partial byte dropped", 2'b00, 12'h030, 1, 32'h77);
    rd_chk("aborted write dropped", 2'b00, 12'h031, 1, 32'h00);
  endtask

  // A second reset with the straps set brings the port up as I2C slave 7'h60.
  task automatic t_i2c();
    logic [7:0] rx;
    logic [9:0] acks;
    logic [15:0] got;
    logic a;
    @(negedge clock);
    rst_n = 1'b0;
    mode_strap = 2'b01;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    `CHK("regs after reset", 8'h00, regs[12'h012])
    repeat (8) @(negedge clock);
    i_scps_host.i2c_start();
    i_scps_host.i2c_byte(8'hC0, 1'b1, rx, acks[0]);
    i_scps_host.i2c_byte(8'h01, 1'b1, rx, acks[1]);
    i_scps_host.i2c_byte(8'h20, 1'b1, rx, acks[2]);
    i_scps_host.i2c_byte(8'h5A, 1'b1, rx, acks[3]);
    i_scps_host.i2c_byte(8'h6B, 1'b1, rx, acks[4]);
    i_scps_host.i2c_stop();
    i_scps_host.i2c_start();
    i_scps_host.i2c_byte(8'hC0, 1'b1, rx, acks[5]);
    i_scps_host.i2c_byte(8'h01, 1'b1, rx, acks[6]);
    i_scps_host.i2c_byte(8'h20, 1'b1, rx, acks[7]);
    i_scps_host.i2c_stop();
    i_scps_host.i2c_start();
    i_scps_host.i2c_byte(8'hC1, 1'b1, rx, acks[8]);
    i_scps_host.i2c_byte(8'hFF, 1'b0, got[15:8], a);
    i_scps_host.i2c_byte(8'hFF, 1'b1, got[7:0], a);
    i_scps_host.i2c_stop();
    `CHK("i2c read from pointer", 16'h5A6B, got)
    i_scps_host.i2c_start();
    i_scps_host.i2c_byte(8'hC0, 1'b1, rx, acks[9]);
    i_scps_host.i2c_byte(8'h01, 1'b1, rx, a);
    i_scps_host.i2c_byte(8'h21, 1'b1, rx, a);
    i_scps_host.i2c_start();
    i_scps_host.i2c_byte(8'hC1, 1'b1, rx, a);
    i_scps_host.i2c_byte(8'hFF, 1'b1, rx, a);
    i_scps_host.i2c_stop();
    `CHK("i2c acks", 10'h000, acks)
    `CHK("i2c combined read", 8'h6B, rx)
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    mode_strap = 2'b00;
    four_wire = 1'b0;
    readback_shadow = 1'b0;
    wrong_pin = 1'b0;
    seen_pin = 1'b0;
    failures = 0;
    compares = 0;
    // Serial clocks run during reset so the link side is reset through its synchroniser.
    fork
      i_scps_host.idle_clocks(4);
      begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
      end
    join
    i_scps_host.idle_clocks(4);
    t_reset();
    t_commit();
    t_multi();
    t_stream();
    t_abort();
    t_i2c();
    results();
  end

  initial begin
    #200000;
    failures++;
    results();
  end
endmodule // scps_top_tb

`default_nettype wire
